// ---- verilog/sic_ctrl.sv ----
// sic_ctrl.sv: direct mapped write-through cache with snoop invalidation
// assumes one clock, inputs synchronous to sys_clk, arbiter outside
//
// Contract
// - during another master's writes the system address is watched and matching lines are invalidated.
// - an invalidation cycle starts only on a snoop hit; misses leave the cache alone.
// - processor reads keep being served from the cache while snooping runs.
// - when the bus is held for a transparent transfer, no new processor read leaves SIC_IDLE; a read already under way, fill included, runs on.
// - the processor address bus is two-way so snoop addresses can be driven in.
// - a read hit gives the first word two clocks after the lookup and three more one clock apart; fill words follow mem_valid.
// - a bus request output tells the arbiter that the shared bus is needed.
`timescale 1ns/1ps
`include "sic_defines.svh"
module sic_ctrl
  import sic_pkg::*;
(
  input  wire logic                    sys_clk,
  input  wire logic                    rst_n,
  input  wire logic                    cpu_rd_req,
  input  wire logic [`SIC_ADDR_W-1:0]  cpu_addr_out,
  input  wire logic                    cpu_addr_oe,
  input  wire logic                    non_cacheable,
  output logic                         cpu_rd_ack,
  output logic                         cpu_rd_first,
  output logic [`SIC_DATA_W-1:0]       cpu_rd_data,
  output logic                         cpu_rd_miss,
  output logic                         bus_need_request,
  input  wire logic                    bus_grant,
  input  wire logic                    bus_hold,
  input  wire logic                    mem_valid,
  input  wire logic [`SIC_DATA_W-1:0]  mem_data,
  input  wire logic                    address_bus_hold_request,
  input  wire logic                    external_snoop_strobe_n,
  input  wire logic [`SIC_ADDR_W-1:0]  snoop_addr_in,
  output logic [`SIC_ADDR_W-1:0]       addr_bus_in,
  output logic                         snoop_inval
);

  // ---------------------------------------------------------------
  // storage
  // ---------------------------------------------------------------
  logic [`SIC_TAG_W-1:0]  tag_mem [`SIC_LINES];
  logic [`SIC_DATA_W-1:0] dat_mem [`SIC_LINES*`SIC_WORDS];
  logic [`SIC_LINES-1:0]  valid_r;

  sic_state_t             state_r;
  logic [`SIC_ADDR_W-1:0] req_addr_r;
  logic [`SIC_ADDR_W-1:0] snp_addr_r;
  logic [1:0]             lat_r;
  logic [1:0]             beat_r;
  logic                   snp_pend_r;

  function automatic logic [`SIC_IDX_W-1:0] idx_of(input logic [`SIC_ADDR_W-1:0] a);
    idx_of = a[`SIC_IDX_LSB +: `SIC_IDX_W];
  endfunction

  function automatic logic [`SIC_TAG_W-1:0] tag_of(input logic [`SIC_ADDR_W-1:0] a);
    tag_of = a[`SIC_TAG_LSB +: `SIC_TAG_W];
  endfunction

  function automatic logic hit_of(input logic [`SIC_ADDR_W-1:0] a,
                                  input logic [`SIC_LINES-1:0] v,
                                  input logic [`SIC_TAG_W-1:0] t);
    hit_of = v[idx_of(a)] && (t == tag_of(a));
  endfunction

  // ---------------------------------------------------------------
  // snoop capture
  // ---------------------------------------------------------------
  // address bus reads back whatever drives it: cpu or snooping master
  assign addr_bus_in = cpu_addr_oe ? cpu_addr_out : snoop_addr_in;

  logic snoop_strobe;
  logic snoop_hit;
  logic cpu_hit;
  assign snoop_strobe = address_bus_hold_request && !external_snoop_strobe_n;
  assign snoop_hit    = hit_of(snp_addr_r, valid_r, tag_mem[idx_of(snp_addr_r)]);
  assign cpu_hit      = hit_of(req_addr_r, valid_r, tag_mem[idx_of(req_addr_r)]);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      snp_pend_r <= 1'b0;
      snp_addr_r <= '0;
    end
    else if (snoop_strobe)
    begin
      snp_pend_r <= 1'b1;
      snp_addr_r <= snoop_addr_in;
    end
    else if (snp_pend_r && state_r != SIC_FILL)
    begin
      snp_pend_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // valid bits
  // ---------------------------------------------------------------
  logic fill_done;
  assign fill_done = (state_r == SIC_FILL) && bus_grant && mem_valid &&
                     (beat_r == `SIC_LAST_BEAT);

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      valid_r <= '0;
    end
    else if (snp_pend_r && state_r != SIC_FILL && snoop_hit)
    begin
      valid_r[idx_of(snp_addr_r)] <= 1'b0;
    end
    else if (fill_done && !non_cacheable)
    begin
      valid_r[idx_of(req_addr_r)] <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    snoop_inval <= rst_n && snp_pend_r && state_r != SIC_FILL && snoop_hit;
  end

  // ---------------------------------------------------------------
  // line fill
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    // uncached fills leave the line untouched
    if (state_r == SIC_FILL && bus_grant && mem_valid && !non_cacheable)
    begin
      dat_mem[{idx_of(req_addr_r), beat_r}] <= mem_data;
      if (beat_r == `SIC_LAST_BEAT)
      begin
        tag_mem[idx_of(req_addr_r)] <= tag_of(req_addr_r);
      end
    end
  end

  // ---------------------------------------------------------------
  // read control
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state_r          <= SIC_IDLE;
      req_addr_r       <= '0;
      lat_r            <= 2'h0;
      beat_r           <= 2'h0;
      cpu_rd_ack       <= 1'b0;
      cpu_rd_first     <= 1'b0;
      cpu_rd_data      <= '0;
      cpu_rd_miss      <= 1'b0;
      bus_need_request <= 1'b0;
    end
    else
    begin
      cpu_rd_ack   <= 1'b0;
      cpu_rd_first <= 1'b0;
      cpu_rd_miss  <= 1'b0;
      case (state_r)
        SIC_IDLE:
        begin
          // hold means the bus belongs to the other master
          if (cpu_rd_req && !bus_hold)
          begin
            req_addr_r <= {cpu_addr_out[`SIC_ADDR_W-1:`SIC_IDX_LSB], `SIC_OFS_W'h0};
            state_r    <= SIC_LOOK;
          end
        end
        SIC_LOOK:
        begin
          // snooping does not stall hits
          if (cpu_hit && !non_cacheable)
          begin
            lat_r   <= `SIC_FIRST_LAT - `SIC_BEAT_LAT;
            beat_r  <= 2'h0;
            state_r <= SIC_BURST;
          end
          else
          begin
            cpu_rd_miss      <= 1'b1;
            bus_need_request <= 1'b1;
            beat_r           <= 2'h0;
            state_r          <= SIC_FILL;
          end
        end
        SIC_BURST:
        begin
          if (lat_r != 2'h0)
          begin
            lat_r <= lat_r - `SIC_BEAT_LAT;
          end
          else
          begin
            cpu_rd_ack   <= 1'b1;
            cpu_rd_first <= (beat_r == 2'h0);
            cpu_rd_data  <= dat_mem[{idx_of(req_addr_r), beat_r}];
            beat_r       <= beat_r + 2'h1;
            if (beat_r == `SIC_LAST_BEAT)
            begin
              state_r <= SIC_IDLE;
            end
          end
        end
        SIC_FILL:
        begin
          if (bus_grant && mem_valid)
          begin
            cpu_rd_ack   <= 1'b1;
            cpu_rd_first <= (beat_r == 2'h0);
            cpu_rd_data  <= mem_data;
            beat_r       <= beat_r + 2'h1;
            if (beat_r == `SIC_LAST_BEAT)
            begin
              bus_need_request <= 1'b0;
              state_r          <= SIC_IDLE;
            end
          end
        end
        default:
        begin
          state_r <= SIC_IDLE;
        end
      endcase
    end
  end

endmodule

// ---- verilog/sic_defines.svh ----
// sic_defines.svh: constants for the snoop invalidate cache controller
// assumes inclusion by bare name from the design file
`ifndef SIC_DEFINES_SVH
`define SIC_DEFINES_SVH
`define SIC_ADDR_W      32
`define SIC_DATA_W      32
`define SIC_IDX_W       6
`define SIC_OFS_W       4
`define SIC_TAG_W       22
`define SIC_TAG_LSB     10
`define SIC_IDX_LSB     4
`define SIC_LINES       64
`define SIC_WORDS       4
`define SIC_FIRST_LAT   2'h2
`define SIC_BEAT_LAT    2'h1
`define SIC_LAST_BEAT   2'h3
`endif

// ---- verilog/sic_pkg.sv ----
// sic_pkg.sv: types for the snoop invalidate cache controller
// assumes sic_defines.svh is available
`include "sic_defines.svh"
package sic_pkg;
  typedef enum logic [2:0] {
    SIC_IDLE  = 3'b000,
    SIC_LOOK  = 3'b001,
    SIC_INV   = 3'b010,
    SIC_BURST = 3'b011,
    SIC_FILL  = 3'b100
  } sic_state_t;
endpackage

// ---- test/sic_ctrl_properties.sv ----
// sic_ctrl_properties.sv: port assertions for sic_ctrl
// assumes bind to sic_ctrl, one clock domain
`timescale 1ns/1ps
module sic_ctrl_properties (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [31:0] cpu_addr_out,
  input wire logic        cpu_addr_oe,
  input wire logic        cpu_rd_ack,
  input wire logic        cpu_rd_first,
  input wire logic [31:0] cpu_rd_data,
  input wire logic        cpu_rd_miss,
  input wire logic        bus_need_request,
  input wire logic        bus_grant,
  input wire logic        mem_valid,
  input wire logic [31:0] mem_data,
  input wire logic [31:0] snoop_addr_in,
  input wire logic [31:0] addr_bus_in
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  addr_cpu_a: assert property (cpu_addr_oe |-> addr_bus_in == cpu_addr_out)
    else $error("cpu addr lost");
  addr_snoop_a: assert property (!cpu_addr_oe |-> addr_bus_in == snoop_addr_in)
    else $error("snoop addr lost");
  first_ack_a: assert property (cpu_rd_first |-> cpu_rd_ack)
    else $error("first without ack");
  hit_beats_a: assert property (cpu_rd_first && !$past(bus_need_request)
    |=> cpu_rd_ack [*3]) else $error("short burst");
  need_rise_a: assert property ($rose(bus_need_request) |-> cpu_rd_miss)
    else $error("request without miss");
  need_stays_a: assert property (bus_need_request && !mem_valid |=> bus_need_request)
    else $error("request dropped");
  fill_ack_a: assert property (bus_need_request && mem_valid && bus_grant
    |=> cpu_rd_ack && cpu_rd_data == $past(mem_data)) else $error("fill word lost");
  fill_gap_a: assert property (bus_need_request && !(mem_valid && bus_grant)
    |=> !cpu_rd_ack) else $error("ack without word");
  cover property (cpu_rd_miss);
  cover property (cpu_rd_first && !bus_need_request);
  cover property (!cpu_addr_oe);
endmodule
bind sic_ctrl sic_ctrl_properties u_sic_ctrl_properties (.*);

// ---- test/sic_mem_model.sv ----
// sic_mem_model.sv: arbiter and memory behind the fill port
// assumes four-word fills, slow stalls every other cycle
`timescale 1ns/1ps
module sic_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        bus_need_request,
  input  wire logic        slow,
  input  wire logic [31:0] base,
  output logic             bus_grant,
  output logic             mem_valid,
  output logic [31:0]      mem_data
);
  logic       ph_r;
  logic [2:0] cnt_r;
  logic       go;
  assign go = bus_need_request && bus_grant && cnt_r < 3'h4 && !ph_r;
  always_ff @(posedge sys_clk)
  begin
    bus_grant <= bus_need_request;
    ph_r      <= slow && !ph_r;
    cnt_r     <= bus_need_request ? cnt_r + {2'h0, go} : 3'h0;
    mem_valid <= go;
    mem_data  <= go ? base + {29'h0, cnt_r} : ~mem_data;
  end
endmodule

// ---- test/sic_ctrl_tb_top.sv ----
// sic_ctrl_tb_top.sv: directed reads, fills and snoops on sic_ctrl
// assumes sic_mem_model answers fills, checker bound to sic_ctrl
`timescale 1ns/1ps
module sic_ctrl_tb_top;
  logic        sys_clk, rst_n, cpu_rd_req, cpu_addr_oe, non_cacheable, bus_hold, slow;
  logic        cpu_rd_ack, cpu_rd_first, cpu_rd_miss, bus_need_request, bus_grant, mem_valid;
  logic        address_bus_hold_request, external_snoop_strobe_n, snoop_inval;
  logic [31:0] cpu_addr_out, snoop_addr_in, mem_data, base, cpu_rd_data, addr_bus_in;
  int          num_errors, check_count;
  sic_ctrl u_sic_ctrl (.*);
  sic_mem_model u_sic_mem_model (.*);
  initial
  begin
    sys_clk = 1'h0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
  begin
    check_count++;
    if (s !== e)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, s, e);
    end
  end
  endtask
  task automatic final_report;
  begin
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  end
  endtask
  task automatic rd(input logic [31:0] a, input logic hit);
    int   n, w;
    logic m;
  begin
    {n, w, m} = '0;
    cpu_addr_out = a;
    cpu_rd_req = 1'h1;
    @(negedge sys_clk);
    cpu_rd_req = 1'h0;
    while (w < 4 && n < 80)
    begin
      @(negedge sys_clk);
      n++;
      m = m | (cpu_rd_miss === 1'h1);
      if (cpu_rd_ack === 1'h1)
      begin
        chk(cpu_rd_data, base + w);
        chk(cpu_rd_first, w == 0);
        if (hit) chk(n, 3 + w);
        w++;
      end
    end
    chk(m, !hit);
    chk(w, 4);
  end
  endtask
  task automatic snp(input logic [31:0] a, input logic hit);
  begin
    cpu_addr_oe = 1'h0;
    snoop_addr_in = a;
    address_bus_hold_request = 1'h1;
    @(negedge sys_clk);
    external_snoop_strobe_n = 1'h0;
    @(negedge sys_clk);
    chk(addr_bus_in, a);
    {address_bus_hold_request, external_snoop_strobe_n} = 2'h1;
    snoop_addr_in = ~a;
    @(negedge sys_clk);
    chk(snoop_inval, hit);
    @(negedge sys_clk);
    chk(snoop_inval, 1'h0);
    cpu_addr_oe = 1'h1;
  end
  endtask
  task automatic held_off;
  begin
    bus_hold = 1'h1;
    cpu_rd_req = 1'h1;
    repeat (6)
    begin
      @(negedge sys_clk);
      chk(cpu_rd_ack | cpu_rd_miss, 0);
    end
    {bus_hold, cpu_rd_req} = 2'h0;
    @(negedge sys_clk);
  end
  endtask
  initial
  begin
    {rst_n, cpu_rd_req, non_cacheable, bus_hold, slow, address_bus_hold_request} = '0;
    {cpu_addr_oe, external_snoop_strobe_n} = 2'h3;
    {cpu_addr_out, snoop_addr_in} = '0;
    base = 32'ha0;
    repeat (4) @(negedge sys_clk);
    rst_n = 1'h1;
    rd(32'h1230, 1'h0);
    rd(32'h1230, 1'h1);
    rd(32'h1234, 1'h1);
    snp(32'h5230, 1'h0);
    rd(32'h1230, 1'h1);
    fork
      rd(32'h1230, 1'h1);
      snp(32'h5230, 1'h0);
    join
    snp(32'h1238, 1'h1);
    {base, slow} = {32'hb0, 1'h1};
    rd(32'h1230, 1'h0);
    rd(32'h1230, 1'h1);
    {base, slow, non_cacheable} = {32'hc0, 2'h1};
    rd(32'h2340, 1'h0);
    rd(32'h2340, 1'h0);
    non_cacheable = 1'h0;
    held_off;
    final_report;
  end
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    num_errors++;
    final_report;
  end
endmodule
